//--- hdl/amrf_defs.vh
// constants for the accelerometer mode, rate and filter control bank
`ifndef AMRF_DEFS_VH
`define AMRF_DEFS_VH

// register locations on the host port
`define AMRF_ADDR_POWER_RATE_AXIS  7'h20
`define AMRF_ADDR_FILTER_REBOOT    7'h21
`define AMRF_ADDR_FILTER_ZERO      7'h25
`define AMRF_ADDR_REFERENCE        7'h26

// reset values
`define AMRF_RST_POWER_RATE_AXIS   8'h07
`define AMRF_RST_FILTER_REBOOT     7'h00
`define AMRF_RST_REFERENCE         8'h00

// power_rate_axis_control fields
`define AMRF_PM_HI                 7
`define AMRF_PM_LO                 5
`define AMRF_DR_HI                 4
`define AMRF_DR_LO                 3
`define AMRF_AXIS_HI               2

// filter_reboot_control fields
`define AMRF_BOOT_BIT              7
`define AMRF_HPM_HI                6
`define AMRF_HPM_LO                5
`define AMRF_FDS_BIT               4
`define AMRF_HIGHPASS_IRQ2_ON_BIT             3
`define AMRF_HIGHPASS_IRQ1_ON_BIT             2
`define AMRF_HPCF_HI               1

// power mode codes and the high-pass reference mode code
`define AMRF_PM_DOWN               3'h0
`define AMRF_PM_NORMAL             3'h1
`define AMRF_PM_LP_MAX             3'h6
`define AMRF_HPM_REFERENCE         2'h1

// timing: all sample rates derive from one base tick
`define AMRF_CLOCK_HZ              200000000
`define AMRF_BASE_HZ               2000
`define AMRF_BASE_DIV              (`AMRF_CLOCK_HZ / `AMRF_BASE_HZ)

// trim copy length in bytes
`define AMRF_TRIM_WORDS            16
`define AMRF_TRIM_LAST             4'hf

`endif

//--- hdl/amrf_control.v
// mode, output rate, high-pass filter and reboot control register bank
`timescale 1ns/100ps
`include "amrf_defs.vh"

module amrf_control #(
  parameter BASE_DIV = `AMRF_BASE_DIV
) (
  // clock and reset
  input  wire       clock,
  input  wire       rstn,
  // register port from the serial host interface
  input  wire [6:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  output reg        reg_rvalid,
  // non-volatile trim memory
  output reg        nvm_rd,
  output reg  [3:0] nvm_addr,
  input  wire [7:0] nvm_data,
  // trim register load
  output reg        trim_we,
  output reg  [3:0] trim_addr,
  output reg  [7:0] trim_data,
  output reg        boot_busy,
  // power and rate control
  output reg        power_down,
  output reg        normal_mode,
  output reg        low_power,
  output reg  [2:0] axis_enable,
  output reg        sample_tick,
  output reg [13:0] output_rate,
  output reg  [1:0] resolution_sel,
  output reg  [9:0] lowpass_cutoff_hz,
  // high-pass filter control
  output reg        hp_ref_mode,
  output reg  [6:0] highpass_coeff,
  output reg [14:0] hp_cutoff_mhz,
  output reg        filtered_output_sel,
  output reg        highpass_irq1_on,
  output reg        highpass_irq2_on,
  output reg        hp_filter_active,
  output reg        filter_zero,
  output reg  [7:0] reference_value
);

  localparam [2:0] S_IDLE  = 3'b001;
  localparam [2:0] S_READ  = 3'b010;
  localparam [2:0] S_WRITE = 3'b100;
  localparam [16:0] BASE_LAST = BASE_DIV[16:0] - 17'h0_0001;
  reg  [7:0] power_rate_axis_control;
  reg  [6:0] filter_reboot_control;
  reg  [7:0] reference;
  reg  [2:0] boot_state;
  reg  [3:0] boot_idx;
  reg        boot_phase;
  reg [16:0] base_cnt;
  reg        base_tick;
  reg [11:0] sample_cnt;
  wire [2:0] power_mode_sel;
  wire [1:0] rate_sel;
  wire [1:0] highpass_mode_sel;
  wire [1:0] highpass_cutoff_sel;
  wire       wr_ctrl1;
  wire       wr_ctrl2;
  wire       boot_req;
  wire [11:0] period;
  wire [25:0] rate_word;
  assign power_mode_sel = power_rate_axis_control[`AMRF_PM_HI:`AMRF_PM_LO];
  assign rate_sel = power_rate_axis_control[`AMRF_DR_HI:`AMRF_DR_LO];
  assign highpass_mode_sel = filter_reboot_control[`AMRF_HPM_HI:`AMRF_HPM_LO];
  assign highpass_cutoff_sel = filter_reboot_control[`AMRF_HPCF_HI:0];
  assign wr_ctrl1 = reg_wr && (reg_addr == `AMRF_ADDR_POWER_RATE_AXIS);
  assign wr_ctrl2 = reg_wr && (reg_addr == `AMRF_ADDR_FILTER_REBOOT);
  assign boot_req = wr_ctrl2 && reg_wdata[`AMRF_BOOT_BIT];
  assign rate_word = rate_info(power_mode_sel, rate_sel);
  assign period = rate_word[25:14];

  // sample period in base ticks over rate in tenths of a hertz;
  // one table keeps the two views of a mode from drifting apart
  function [25:0] rate_info;
    input [2:0] pm;
    input [1:0] dr;
    begin
      case (pm)
        3'h1:
          case (dr)
            2'h0: rate_info = {12'd40, 14'd500};
            2'h1: rate_info = {12'd20, 14'd1000};
            2'h2: rate_info = {12'd5, 14'd4000};
            default: rate_info = {12'd2, 14'd10000};
          endcase
        3'h2: rate_info = {12'd4000, 14'd5};
        3'h3: rate_info = {12'd2000, 14'd10};
        3'h4: rate_info = {12'd1000, 14'd20};
        3'h5: rate_info = {12'd400, 14'd50};
        3'h6: rate_info = {12'd200, 14'd100};
        default: rate_info = {12'd0, 14'd0};
      endcase
    end
  endfunction

  function [9:0] lowpass_hz;
    input [1:0] dr;
    begin
      case (dr)
        2'h0: lowpass_hz = 10'd37;
        2'h1: lowpass_hz = 10'd74;
        2'h2: lowpass_hz = 10'd292;
        default: lowpass_hz = 10'd780;
      endcase
    end
  endfunction
  // cut-off at coefficient 8 per rate, halved for each coefficient step
  function [14:0] hp_cutoff;
    input [1:0] dr;
    input [1:0] cf;
    reg   [14:0] top;
    begin
      top = 15'd1000;
      case (dr)
        2'h0: top = 15'd1000;
        2'h1: top = 15'd2000;
        2'h2: top = 15'd8000;
        default: top = 15'd20000;
      endcase
      hp_cutoff = top >> cf;
    end
  endfunction

  // register writes; reboot bit is held by the copy engine, not stored
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      power_rate_axis_control <= `AMRF_RST_POWER_RATE_AXIS;
      filter_reboot_control <= `AMRF_RST_FILTER_REBOOT;
      reference <= `AMRF_RST_REFERENCE;
    end
    else
    begin
      if (wr_ctrl1)
        power_rate_axis_control <= reg_wdata;
      if (wr_ctrl2)
        filter_reboot_control <= reg_wdata[6:0];
      if (reg_wr && (reg_addr == `AMRF_ADDR_REFERENCE))
        reference <= reg_wdata;
    end
  end

  // register reads; the filter-zero location reads as zero
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      filter_zero <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      filter_zero <= reg_rd && (reg_addr == `AMRF_ADDR_FILTER_ZERO);
      if (reg_rd)
      begin
        if (reg_addr == `AMRF_ADDR_POWER_RATE_AXIS)
          reg_rdata <= power_rate_axis_control;
        else if (reg_addr == `AMRF_ADDR_FILTER_REBOOT)
          reg_rdata <= {boot_state != S_IDLE, filter_reboot_control};
        else if (reg_addr == `AMRF_ADDR_REFERENCE)
          reg_rdata <= reference;
        else
          reg_rdata <= 8'h00;
      end
    end
  end

  // trim copy engine: starts on its own out of reset
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      boot_state <= S_READ;
      boot_idx <= 4'h0;
      boot_phase <= 1'b0;
      nvm_rd <= 1'b0;
      nvm_addr <= 4'h0;
      trim_we <= 1'b0;
      trim_addr <= 4'h0;
      trim_data <= 8'h00;
      boot_busy <= 1'b0;
    end
    else
    begin
      nvm_rd <= 1'b0;
      trim_we <= 1'b0;
      boot_busy <= (boot_state != S_IDLE);
      case (boot_state)
        S_IDLE:
          if (boot_req)
          begin
            boot_idx <= 4'h0;
            boot_state <= S_READ;
          end
        S_READ:
        begin
          // one idle cycle lets the memory answer the registered request
          if (!boot_phase)
          begin
            nvm_rd <= 1'b1;
            nvm_addr <= boot_idx;
            boot_phase <= 1'b1;
          end
          else
          begin
            boot_phase <= 1'b0;
            boot_state <= S_WRITE;
          end
        end
        S_WRITE:
        begin
          trim_we <= 1'b1;
          trim_addr <= boot_idx;
          trim_data <= nvm_data;
          if (boot_idx == `AMRF_TRIM_LAST)
          begin
            boot_idx <= 4'h0;
            // a new request on the last byte restarts instead of ending
            boot_state <= boot_req ? S_READ : S_IDLE;
          end
          else
          begin
            boot_idx <= boot_idx + 4'h1;
            boot_state <= S_READ;
          end
        end
        default:
          boot_state <= S_IDLE;
      endcase
    end
  end

  // base tick divider and sample rate counter
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      base_cnt <= 17'h0_0000;
      base_tick <= 1'b0;
      sample_cnt <= 12'h000;
      sample_tick <= 1'b0;
    end
    else
    begin
      base_tick <= (base_cnt == BASE_LAST);
      if (base_cnt == BASE_LAST)
        base_cnt <= 17'h0_0000;
      else
        base_cnt <= base_cnt + 17'h0_0001;
      sample_tick <= 1'b0;
      if (period == 12'h000)
        sample_cnt <= 12'h000;
      else if (base_tick)
      begin
        // shrinking the period mid-count wraps on the next base tick, never overruns
        if (sample_cnt >= period - 12'h001)
        begin
          sample_cnt <= 12'h000;
          sample_tick <= 1'b1;
        end
        else
          sample_cnt <= sample_cnt + 12'h001;
      end
    end
  end

  // decoded control outputs, one cycle behind the registers
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      power_down <= 1'b1;
      normal_mode <= 1'b0;
      low_power <= 1'b0;
      axis_enable <= 3'h7;
      output_rate <= 14'h0000;
      resolution_sel <= 2'h0;
      lowpass_cutoff_hz <= 10'd37;
      hp_ref_mode <= 1'b0;
      highpass_coeff <= 7'd8;
      hp_cutoff_mhz <= 15'd1000;
      filtered_output_sel <= 1'b0;
      highpass_irq1_on <= 1'b0;
      highpass_irq2_on <= 1'b0;
      hp_filter_active <= 1'b0;
      reference_value <= 8'h00;
    end
    else
    begin
      power_down <= (power_mode_sel == `AMRF_PM_DOWN);
      normal_mode <= (power_mode_sel == `AMRF_PM_NORMAL);
      low_power <= (power_mode_sel > `AMRF_PM_NORMAL) &&
                   (power_mode_sel <= `AMRF_PM_LP_MAX);
      axis_enable <= power_rate_axis_control[`AMRF_AXIS_HI:0];
      output_rate <= rate_word[13:0];
      resolution_sel <= rate_sel;
      lowpass_cutoff_hz <= lowpass_hz(rate_sel);
      hp_ref_mode <= (highpass_mode_sel == `AMRF_HPM_REFERENCE);
      highpass_coeff <= 7'd8 << highpass_cutoff_sel;
      hp_cutoff_mhz <= hp_cutoff(rate_sel, highpass_cutoff_sel);
      filtered_output_sel <= filter_reboot_control[`AMRF_FDS_BIT];
      highpass_irq1_on <= filter_reboot_control[`AMRF_HIGHPASS_IRQ1_ON_BIT];
      highpass_irq2_on <= filter_reboot_control[`AMRF_HIGHPASS_IRQ2_ON_BIT];
      hp_filter_active <= filter_reboot_control[`AMRF_FDS_BIT] |
                          filter_reboot_control[`AMRF_HIGHPASS_IRQ1_ON_BIT] |
                          filter_reboot_control[`AMRF_HIGHPASS_IRQ2_ON_BIT];
      reference_value <= reference;
    end
  end

endmodule

//--- verification/amrf_nvm_model.sv
// trim memory model answering fetches from the copy engine
`timescale 1ns/100ps
module amrf_nvm_model (
  // clock
  input  wire       clock,
  // fetch port
  input  wire       nvm_rd,
  input  wire [3:0] nvm_addr,
  output logic [7:0] nvm_data
);
  // data valid from the edge that sees the fetch; toggles otherwise
  // so a late capture cannot pass by luck
  always @(posedge clock)
  begin
    nvm_data <= nvm_rd ? {4'ha, nvm_addr} : ~nvm_data;
  end
endmodule

//--- verification/amrf_control_assertions.sv
// concurrent checks for the mode, rate and filter control bank
`timescale 1ns/100ps
module amrf_control_assertions (
  // clock and reset
  input wire       clock,
  input wire       rstn,
  // register port
  input wire [6:0] reg_addr,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // trim copy
  input wire       nvm_rd,
  input wire       trim_we,
  // decoded controls
  input wire       power_down,
  input wire       sample_tick,
  input wire       filtered_output_sel,
  input wire       hp_filter_active,
  input wire       filter_zero
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_byte;
    !nvm_rd ##1 trim_we;
  endsequence
  sequence s_zero_rd;
    reg_rd && reg_addr == 7'h25;
  endsequence
  sequence s_wr2;
    reg_wr && reg_addr == 7'h21;
  endsequence
  property p_copy_byte;
    nvm_rd |=> s_byte;
  endproperty
  property p_trim_cause;
    trim_we |-> $past(nvm_rd, 2);
  endproperty
  property p_zero_pulse;
    s_zero_rd |=> filter_zero && reg_rdata == 8'h00;
  endproperty
  property p_zero_cause;
    filter_zero |-> $past(reg_rd) && $past(reg_addr) == 7'h25;
  endproperty
  property p_down_quiet;
    $past(power_down) && power_down |-> !sample_tick;
  endproperty
  property p_pd_write;
    reg_wr && reg_addr == 7'h20 && reg_wdata[7:5] == 3'h0 |=> ##1 power_down;
  endproperty
  property p_fds_write;
    s_wr2 |=> ##1 filtered_output_sel == $past(reg_wdata[4], 2);
  endproperty
  property p_active_write;
    s_wr2 |=> ##1 hp_filter_active == |$past(reg_wdata[4:2], 2);
  endproperty
  property p_tick_pulse;
    sample_tick |=> !sample_tick;
  endproperty
  a_copy_byte: assert property (p_copy_byte)
    else $error("trim byte not written after fetch");
  a_trim_cause: assert property (p_trim_cause)
    else $error("trim write without fetch");
  a_zero_pulse: assert property (p_zero_pulse)
    else $error("filter zero read misbehaved");
  a_zero_cause: assert property (p_zero_cause)
    else $error("filter zero without read");
  a_down_quiet: assert property (p_down_quiet)
    else $error("sample in power-down");
  a_pd_write: assert property (p_pd_write)
    else $error("power-down not entered");
  a_fds_write: assert property (p_fds_write)
    else $error("filtered output select wrong");
  a_active_write: assert property (p_active_write)
    else $error("filter active flag wrong");
  a_tick_pulse: assert property (p_tick_pulse)
    else $error("sample tick too long");
endmodule

bind amrf_control amrf_control_assertions u_chk (
  .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .nvm_rd(nvm_rd), .trim_we(trim_we), .power_down(power_down),
  .sample_tick(sample_tick), .filtered_output_sel(filtered_output_sel),
  .hp_filter_active(hp_filter_active), .filter_zero(filter_zero));

//--- verification/amrf_control_tb_top.sv
// self-checking bench for the mode, rate and filter control bank
`timescale 1ns/100ps
module amrf_control_tb_top;
  logic        clock = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
  logic [6:0]  reg_addr = 7'h00;
  logic [7:0]  reg_wdata = 8'h00;
  wire  [7:0]  reg_rdata, nvm_data, trim_data, reference_value;
  wire  [3:0]  nvm_addr, trim_addr;
  wire         reg_rvalid, nvm_rd, trim_we, boot_busy, power_down;
  wire         normal_mode, low_power, sample_tick, hp_ref_mode, fos;
  wire         irq1, irq2, hp_filter_active, filter_zero;
  wire  [2:0]  axis_enable;
  wire  [1:0]  resolution_sel;
  wire  [13:0] output_rate;
  wire  [9:0]  lowpass_cutoff_hz;
  wire  [6:0]  highpass_coeff;
  wire  [14:0] hp_cutoff_mhz;
  integer      failures = 0, n_checks = 0, trims = 0, cycles = 0, pm, dr, v;
  logic [7:0]  w;
  logic [15:0] nr_tab [4] = '{16'h01f4, 16'h03e8, 16'h0fa0, 16'h2710};
  logic [15:0] lp_tab [4] = '{16'h0025, 16'h004a, 16'h0124, 16'h030c};
  logic [15:0] lr_tab [5] = '{16'h0005, 16'h000a, 16'h0014, 16'h0032,
                              16'h0064};

  amrf_control #(.BASE_DIV(4)) DUT (
    .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr),
    .nvm_data(nvm_data), .trim_we(trim_we), .trim_addr(trim_addr),
    .trim_data(trim_data), .boot_busy(boot_busy), .power_down(power_down),
    .normal_mode(normal_mode), .low_power(low_power),
    .axis_enable(axis_enable), .sample_tick(sample_tick),
    .output_rate(output_rate), .resolution_sel(resolution_sel),
    .lowpass_cutoff_hz(lowpass_cutoff_hz), .hp_ref_mode(hp_ref_mode),
    .highpass_coeff(highpass_coeff), .hp_cutoff_mhz(hp_cutoff_mhz),
    .filtered_output_sel(fos), .highpass_irq1_on(irq1),
    .highpass_irq2_on(irq2), .hp_filter_active(hp_filter_active),
    .filter_zero(filter_zero), .reference_value(reference_value));
  amrf_nvm_model u_nvm (
    .clock(clock), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr),
    .nvm_data(nvm_data));

  always #2.5 clock = ~clock;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
    chk(reg_rvalid, 1'b1);
    chk(filter_zero, a == 7'h25);
  endtask
  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic wait_boot;
    integer n;
    n = 0;
    while (boot_busy !== 1'b0 && n < 200)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(boot_busy, 1'b0);
  endtask
  // time from one sample tick to the next, bounded
  task automatic tick_gap(input logic [15:0] exp);
    integer n;
    // first look is after the edge that sees the new mode settle
    n = 0;
    do
    begin
      @(posedge clock); #1; n++;
    end while (sample_tick !== 1'b1 && n < 2000);
    n = 0;
    do
    begin
      @(posedge clock); #1; n++;
    end while (sample_tick !== 1'b1 && n < 2000);
    chk(n[15:0], exp);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(negedge clock)
  begin
    if (trim_we === 1'b1)
    begin
      trims++;
      chk(trim_data, {4'ha, trim_addr});
    end
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      report_and_stop;
    end
  end

  initial
  begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    #1 chk({power_down, lowpass_cutoff_hz}, 16'h0425);
    chk(highpass_coeff, 16'h0008);
    rd(7'h21, 8'h80);
    wait_boot;
    chk(trims, 16'h0010);
    rd(7'h20, 8'h07);
    rd(7'h21, 8'h00);
    rd(7'h26, 8'h00);
    for (pm = 0; pm < 7; pm++)
      for (dr = 0; dr < 4; dr++)
      begin
        wr(7'h20, {pm[2:0], dr[1:0], 3'h5});
        settle;
        chk(output_rate, pm == 0 ? 16'h0 : pm == 1 ? nr_tab[dr] :
            lr_tab[pm-2]);
        chk(lowpass_cutoff_hz, lp_tab[dr]);
        chk(resolution_sel, dr[1:0]);
        chk(axis_enable, 3'h5);
        chk({power_down, normal_mode, low_power},
            {pm == 0, pm == 1, pm > 1});
      end
    wr(7'h20, 8'h3f);
    tick_gap(16'h0008);
    wr(7'h20, 8'hdf);
    tick_gap(16'h0320);
    wr(7'h20, 8'h3f);
    for (v = 0; v < 16; v++)
    begin
      w = {1'b0, v[3:2], v[0], v[2], v[1], v[1:0]};
      wr(7'h21, w);
      rd(7'h21, w);
      settle;
      chk(highpass_coeff, 16'h0008 << v[1:0]);
      chk(hp_cutoff_mhz, 16'h4e20 >> v[1:0]);
      chk(hp_ref_mode, v[3:2] == 2'h1);
      chk({fos, irq2, irq1}, w[4:2]);
      chk(hp_filter_active, |w[4:2]);
    end
    wr(7'h20, 8'h07);
    settle;
    chk(hp_cutoff_mhz, 16'h007d);
    wr(7'h21, 8'h80);
    rd(7'h21, 8'h80);
    wait_boot;
    rd(7'h21, 8'h00);
    chk(trims, 16'h0020);
    wr(7'h26, 8'ha5);
    rd(7'h26, 8'ha5);
    chk(reference_value, 8'ha5);
    rd(7'h25, 8'h00);
    wr(7'h30, 8'hff);
    rd(7'h30, 8'h00);
    report_and_stop;
  end
endmodule
